/* hw/sense_sync_ctrl.sv */
// Sense feedback gating, offset mode and sampling strobe generator with APB registers
`default_nettype none
module sense_sync_ctrl #(
  parameter int unsigned BLANK_CYC = sense_sync_pkg::BLANK_CYC,
  parameter int unsigned FAIL_HALF_CYC = sense_sync_pkg::FAIL_HALF_CYC,
  parameter int unsigned FULL_PULSE_CYC = sense_sync_pkg::FULL_PULSE_CYC,
  parameter int unsigned VOLT_HALF = sense_sync_pkg::VOLT_HALF
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire sense_sync_pkg::apb_req_s apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire sense_sync_pkg::dev_mode_e dev_mode,
  input wire sense_sync_pkg::chan_s chan,
  input wire logic pwm_cycle_start,
  input wire logic pwm_clk_tick,
  input wire logic pwm_clock_fail,
  input wire logic sense_sample_strobe_n_i,
  output logic sense_sample_strobe_n_o,
  output logic sense_sample_strobe_n_oe,
  output logic sense_feedback_enable,
  output logic offset_sign,
  output logic [3:0] sense_full_scale_half
);
  sense_sync_pkg::state_s s;
  sense_sync_pkg::state_s next_s;

  // Count with saturation at zero, shared by the blanking and pulse timers
  function automatic logic [sense_sync_pkg::CNT_W-1:0] count_down(
    input logic [sense_sync_pkg::CNT_W-1:0] v);
    count_down = (v == '0) ? v : v - 1'b1;
  endfunction

  logic [2:0] sel;
  logic [1:0] ch;
  logic normal;
  logic cur_sel;
  logic volt_sel;
  logic acm_sel;
  logic ch_on;
  logic ch_inrush;
  logic ch_full;
  logic ch_fault;
  logic changed;
  logic blanked;
  logic valid;
  logic mid_hit;
  logic full_low;
  logic low;
  logic setup;
  logic access_wr;
  logic hit_ctrl;
  logic hit_status;
  sense_sync_pkg::strobe_mode_e mode;

  // Selection decode and per-channel views of the selected output
  always_comb begin
    sel = s.feedback_select;
    ch = sel[1:0];
    normal = (dev_mode == sense_sync_pkg::DEV_NORMAL);
    cur_sel = ~sel[2];
    volt_sel = (sel == sense_sync_pkg::SEL_TEMP) || (sel == sense_sync_pkg::SEL_VBAT);
    acm_sel = cur_sel && s.offset_mode_enable[ch];
    ch_on = chan.on_phase[ch];
    ch_inrush = chan.inrush[ch];
    ch_full = chan.full_duty[ch];
    ch_fault = chan.fault[ch];
    mode = sense_sync_pkg::strobe_mode_e'({s.strobe_select_hi, s.strobe_select_lo});
  end

  // Bus decode; the answer is ready in the access phase, with wait states only while ce is low
  always_comb begin
    setup = apb_req.psel && !apb_req.penable;
    access_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    hit_ctrl = (apb_req.paddr == sense_sync_pkg::CTRL_OFS);
    hit_status = (apb_req.paddr == sense_sync_pkg::STATUS_OFS);
  end

  // Whole next state, including the strobe decision
  always_comb begin
    next_s = s;
    // Mux or offset mode switch restarts blanking and the trigger waits
    changed = (sel != s.prev_sel) || (acm_sel != s.prev_acm);
    next_s.prev_sel = sel;
    next_s.prev_acm = acm_sel;
    if (changed) begin
      next_s.blank_cnt = sense_sync_pkg::CNT_W'(BLANK_CYC);
      next_s.wait_cycle = 1'b1;
      next_s.wait_mid = 1'b1;
    end else begin
      next_s.blank_cnt = count_down(s.blank_cnt);
      if (pwm_cycle_start) begin
        next_s.wait_cycle = 1'b0;
      end
    end
    blanked = changed || (s.blank_cnt != '0);

    // Fault holds off triggers until the output turns on again; set wins
    next_s.prev_on = ch_on;
    if (ch_fault) begin
      next_s.fault_block = 1'b1;
    end else if (ch_on && !s.prev_on) begin
      next_s.fault_block = 1'b0;
    end

    // On-phase length of the last pulse locates the next midpoint
    if (ch_on) begin
      next_s.on_cnt = (s.on_cnt == '1) ? s.on_cnt : s.on_cnt + 1'b1;
    end else begin
      next_s.on_cnt = '0;
      if (s.prev_on) begin
        next_s.on_len = s.on_cnt;
      end
    end
    mid_hit = ch_on && (s.on_cnt == (s.on_len >> 1));

    // Current feedback only in normal mode, on phase and past inrush
    next_s.sense_en = normal && cur_sel && ch_on && !ch_inrush;
    valid = normal && cur_sel && ch_on && !ch_inrush && !blanked
      && !s.fault_block && !ch_fault;

    // Midpoint window; a change keeps it shut until a clean midpoint
    if (!valid) begin
      next_s.mid_low = 1'b0;
    end else if (mid_hit) begin
      next_s.wait_mid = changed;
      next_s.mid_low = 1'b1;
    end

    // High pulse at each counter overflow when the channel runs at 100 % in the next-cycle or midpoint setting
    if (pwm_cycle_start) begin
      next_s.full_cnt = sense_sync_pkg::CNT_W'(FULL_PULSE_CYC);
    end else begin
      next_s.full_cnt = count_down(s.full_cnt);
    end
    full_low = valid && (s.full_cnt == '0) && !pwm_cycle_start;

    // Free-running fallback square wave for a dead PWM clock
    if (s.fail_cnt >= sense_sync_pkg::CNT_W'(FAIL_HALF_CYC - 1)) begin
      next_s.fail_cnt = '0;
      next_s.fail_level = ~s.fail_level;
    end else begin
      next_s.fail_cnt = s.fail_cnt + 1'b1;
    end

    // Voltage square wave from the slowest prescaler tap
    if (pwm_clk_tick) begin
      if (s.volt_cnt >= 10'(VOLT_HALF - 1)) begin
        next_s.volt_cnt = '0;
        next_s.volt_level = ~s.volt_level;
      end else begin
        next_s.volt_cnt = s.volt_cnt + 1'b1;
      end
    end

    // Strobe pull-low decision, clock failure taking priority
    low = 1'b0;
    if (!normal) begin
      low = 1'b0;
    end else if (pwm_clock_fail && (cur_sel || volt_sel)) begin
      low = !s.fail_level;
    end else if (volt_sel) begin
      low = !s.volt_level;
    end else if (cur_sel) begin
      case (mode)
        sense_sync_pkg::STROBE_OFF: begin
          low = 1'b0;
        end
        sense_sync_pkg::STROBE_VALID: begin
          low = valid;
        end
        sense_sync_pkg::STROBE_NEXT_CYCLE: begin
          low = ch_full ? full_low : (valid && !s.wait_cycle);
        end
        sense_sync_pkg::STROBE_MIDPOINT: begin
          low = ch_full ? full_low : (valid && !s.wait_mid && (s.mid_low || mid_hit));
        end
        default: begin
          low = 1'b0;
        end
      endcase
    end
    next_s.strobe_low = low;

    // Offset sign flips on each strobe rising edge, cleared when mode is off
    next_s.prev_pin = sense_sample_strobe_n_i;
    if (!acm_sel) begin
      next_s.offset_sign = 1'b0;
    end else if (sense_sample_strobe_n_i && !s.prev_pin) begin
      next_s.offset_sign = ~s.offset_sign;
    end

    // Register read data is captured in the setup phase
    if (setup) begin
      next_s.err = !(hit_ctrl || hit_status);
      next_s.rdata = '0;
      if (hit_ctrl) begin
        next_s.rdata[sense_sync_pkg::SEL_LSB +: 3] = s.feedback_select;
        next_s.rdata[sense_sync_pkg::STROBE_LO_BIT] = s.strobe_select_lo;
        next_s.rdata[sense_sync_pkg::STROBE_HI_BIT] = s.strobe_select_hi;
        next_s.rdata[sense_sync_pkg::ACM_LSB +: 4] = s.offset_mode_enable;
      end else if (hit_status) begin
        next_s.rdata[sense_sync_pkg::ST_STROBE_BIT] = s.strobe_low;
        next_s.rdata[sense_sync_pkg::ST_SENSE_BIT] = s.sense_en;
        next_s.rdata[sense_sync_pkg::ST_SIGN_BIT] = s.offset_sign;
        next_s.rdata[sense_sync_pkg::ST_CLKFAIL_BIT] = pwm_clock_fail;
        next_s.rdata[sense_sync_pkg::ST_BLANK_BIT] = blanked;
        next_s.rdata[sense_sync_pkg::ST_FAULT_BIT] = s.fault_block;
      end
    end

    // Control write takes effect at the access edge
    if (access_wr && hit_ctrl) begin
      next_s.feedback_select = apb_req.pwdata[sense_sync_pkg::SEL_LSB +: 3];
      next_s.strobe_select_lo = apb_req.pwdata[sense_sync_pkg::STROBE_LO_BIT];
      next_s.strobe_select_hi = apb_req.pwdata[sense_sync_pkg::STROBE_HI_BIT];
      next_s.offset_mode_enable = apb_req.pwdata[sense_sync_pkg::ACM_LSB +: 4];
    end
    // Fail mode overrides any software write to the offset enables
    if (dev_mode == sense_sync_pkg::DEV_FAIL) begin
      next_s.offset_mode_enable = '0;
    end
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= sense_sync_pkg::STATE_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Ready follows the clock enable so no write is lost while frozen
  assign pready = ce;
  assign pslverr = apb_req.psel && apb_req.penable && s.err;
  assign prdata = s.rdata;
  // Open drain: only ever pull low, the pull-up makes the high level
  assign sense_sample_strobe_n_o = 1'b0;
  assign sense_sample_strobe_n_oe = s.strobe_low;
  assign sense_feedback_enable = s.sense_en;
  assign offset_sign = s.offset_sign;
  assign sense_full_scale_half = s.offset_mode_enable;
endmodule
`default_nettype wire

/* hw/sense_sync_pkg.sv */
// Constants, types and reset values for the sense feedback strobe controller
`default_nettype none
package sense_sync_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned ON_W = 24;
  localparam int unsigned ADDR_W = 12;
  // Timing: printed figures in their own unit, cycle counts derived
  localparam int unsigned TURN_ON_DELAY_NS = 50000;
  localparam int unsigned SENSE_SETTLING_NS = 100000;
  localparam int unsigned BLANK_CYC = ((TURN_ON_DELAY_NS + SENSE_SETTLING_NS) * CLK_MHZ + 999) / 1000;
  localparam int unsigned FAIL_PERIOD_US = 6500;
  localparam int unsigned FAIL_HALF_CYC = FAIL_PERIOD_US * CLK_MHZ / 2;
  localparam int unsigned FULL_PULSE_US = 100;
  localparam int unsigned FULL_PULSE_CYC = FULL_PULSE_US * CLK_MHZ;
  localparam int unsigned VOLT_DIV = 1024;
  localparam int unsigned VOLT_HALF = VOLT_DIV / 2;
  // Register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned STROBE_LO_BIT = 3;
  localparam int unsigned STROBE_HI_BIT = 4;
  localparam int unsigned ACM_LSB = 8;
  localparam int unsigned ST_STROBE_BIT = 0;
  localparam int unsigned ST_SENSE_BIT = 1;
  localparam int unsigned ST_SIGN_BIT = 2;
  localparam int unsigned ST_CLKFAIL_BIT = 3;
  localparam int unsigned ST_BLANK_BIT = 4;
  localparam int unsigned ST_FAULT_BIT = 5;
  // Feedback select codes
  localparam logic [2:0] SEL_TEMP = 3'h4;
  localparam logic [2:0] SEL_VBAT = 3'h5;

  typedef enum logic [1:0] {
    STROBE_OFF = 2'b00,
    STROBE_VALID = 2'b01,
    STROBE_NEXT_CYCLE = 2'b10,
    STROBE_MIDPOINT = 2'b11
  } strobe_mode_e;

  typedef enum logic [1:0] {
    DEV_NORMAL = 2'b00,
    DEV_FAIL = 2'b01,
    DEV_SLEEP = 2'b10
  } dev_mode_e;

  typedef struct packed {
    logic [3:0] on_phase;
    logic [3:0] inrush;
    logic [3:0] full_duty;
    logic [3:0] fault;
  } chan_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [2:0] feedback_select;
    logic strobe_select_lo;
    logic strobe_select_hi;
    logic [3:0] offset_mode_enable;
    logic offset_sign;
    logic strobe_low;
    logic sense_en;
    logic [CNT_W-1:0] blank_cnt;
    logic wait_cycle;
    logic wait_mid;
    logic mid_low;
    logic fault_block;
    logic [ON_W-1:0] on_cnt;
    logic [ON_W-1:0] on_len;
    logic [CNT_W-1:0] full_cnt;
    logic [CNT_W-1:0] fail_cnt;
    logic fail_level;
    logic [9:0] volt_cnt;
    logic volt_level;
    logic [2:0] prev_sel;
    logic prev_acm;
    logic prev_on;
    logic prev_pin;
    logic [31:0] rdata;
    logic err;
  } state_s;

  localparam state_s STATE_RST = '0;
endpackage
`default_nettype wire

/* testbench/sense_sync_asserts.sv */
// Concurrent checks on the strobe controller ports
`default_nettype none
module sense_sync_asserts #(parameter int unsigned FAIL_HALF_CYC = 50) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire sense_sync_pkg::apb_req_s apb_req,
  input wire logic pready,
  input wire sense_sync_pkg::dev_mode_e dev_mode,
  input wire sense_sync_pkg::chan_s chan,
  input wire logic pwm_clock_fail,
  input wire logic sense_sample_strobe_n_i,
  input wire logic sense_sample_strobe_n_o,
  input wire logic sense_sample_strobe_n_oe,
  input wire logic sense_feedback_enable,
  input wire logic offset_sign,
  input wire logic [3:0] sense_full_scale_half
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [11:0] ctrl;
  int unsigned hold;
  logic wr, nrm, cur, act, oe;
  logic [1:0] ch;
  // Shadow of the control word, so checks know the select and strobe setting
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && pready && apb_req.paddr == sense_sync_pkg::CTRL_OFS;
  assign nrm = dev_mode == sense_sync_pkg::DEV_NORMAL;
  assign ch = ctrl[1:0];
  assign cur = !ctrl[2] && ce && nrm;
  assign act = chan.on_phase[ch] && !chan.inrush[ch] && !chan.fault[ch];
  assign oe = sense_sample_strobe_n_oe;
  // Hold counter only runs under clock failure; a change of level restarts it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= '0;
      hold <= 0;
    end else begin
      if (wr) ctrl <= apb_req.pwdata[11:0];
      hold <= ($changed(oe) || !pwm_clock_fail) ? 0 : hold + 1;
    end
  end
  AST_MODE_GATE: assert property ((ce && !nrm) |=> !oe && !sense_feedback_enable)
    else $error("strobe or feedback outside normal mode");
  AST_DRAIN: assert property (sense_sample_strobe_n_o == 1'b0)
    else $error("strobe pin driven high");
  AST_FB_GATE: assert property ((cur && !(chan.on_phase[ch] && !chan.inrush[ch])) |=> !sense_feedback_enable)
    else $error("feedback while off or in inrush");
  AST_OFF_IDLE: assert property ((cur && !pwm_clock_fail && ctrl[4:3] == 2'b00) |=> !oe)
    else $error("strobe active in off setting");
  AST_NO_TRIG: assert property ((cur && !pwm_clock_fail && ctrl[4:3] != 2'b00 && !chan.full_duty[ch] && !act)
    |=> !oe)
    else $error("strobe in off phase, inrush or fault");
  AST_BLANK: assert property ((wr && ce && nrm && !pwm_clock_fail && !apb_req.pwdata[2] && apb_req.pwdata[1:0] != ch)
    |=> ##1 !oe [*8])
    else $error("strobe not blanked after select change");
  AST_SIGN: assert property (($rose(sense_sample_strobe_n_i) && cur && ctrl[8 + ch]) |-> ##[1:2] offset_sign != $past(offset_sign))
    else $error("offset sign not flipped");
  AST_FAIL_RANGE: assert property ((ce && dev_mode == sense_sync_pkg::DEV_FAIL) |-> ##[1:2] sense_full_scale_half == 4'h0)
    else $error("offset mode kept in fail mode");
  AST_CLKFAIL: assert property ((nrm && ctrl[2:1] != 2'b11) |-> hold < FAIL_HALF_CYC + 4)
    else $error("clock fail wave half period too long");
  // Main scenarios reached
  cover property (wr && apb_req.pwdata[2]);
  cover property (pwm_clock_fail && $rose(oe));
  cover property ($rose(sense_sample_strobe_n_i) && ctrl[8]);
endmodule
bind sense_sync_ctrl sense_sync_asserts #(.FAIL_HALF_CYC(FAIL_HALF_CYC)) sense_sync_asserts_inst (.*);
`default_nettype wire

/* testbench/adc_sampler.sv */
// Host converter model: sees the open-drain strobe through its pull-up
`default_nettype none
module adc_sampler (
  input wire logic mclk,
  input wire logic pull_low,
  output logic pin_n,
  output int samples
);
  logic prev = 1'b1;
  initial samples = 0;
  assign pin_n = !pull_low;
  // One sample counted per falling edge of the strobe pin
  always @(posedge mclk) begin
    prev <= pin_n;
    if (prev && !pin_n) samples <= samples + 1;
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the strobe controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
  localparam logic [11:0] C = sense_sync_pkg::CTRL_OFS;
  localparam logic [11:0] S = sense_sync_pkg::STATUS_OFS;
  logic mclk = 0, nrst = 0, ce = 1, cs = 0, ck = 0, cf = 0, s0;
  sense_sync_pkg::apb_req_s req = '0;
  sense_sync_pkg::dev_mode_e mode = sense_sync_pkg::DEV_NORMAL;
  sense_sync_pkg::chan_s chan = '0;
  logic pready, pslverr, oe, drv0, fb, sign, pin;
  logic [31:0] prdata;
  logic [3:0] half;
  int samples, n0, miscompares = 0, num_checks = 0;
  integer seed = 35859;
  exp_s q[$];
  sense_sync_ctrl #(.BLANK_CYC(20), .FAIL_HALF_CYC(50), .FULL_PULSE_CYC(10), .VOLT_HALF(4)) sense_sync_ctrl_inst (
    .mclk(mclk), .nrst(nrst), .ce(ce), .apb_req(req), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .dev_mode(mode), .chan(chan), .pwm_cycle_start(cs), .pwm_clk_tick(ck), .pwm_clock_fail(cf),
    .sense_sample_strobe_n_i(pin), .sense_sample_strobe_n_o(drv0), .sense_sample_strobe_n_oe(oe),
    .sense_feedback_enable(fb), .offset_sign(sign), .sense_full_scale_half(half));
  adc_sampler adc_sampler_inst (.mclk(mclk), .pull_low(oe), .pin_n(pin), .samples(samples));
  // Clock and random prescaler ticks
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) ck <= 1'($random(seed));
  task automatic check(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk) req.penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, m, input logic e = 0);
    q.push_back('{d, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pulse;
    cs <= 1'b1;
    @(posedge mclk) cs <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Read results are compared against the oldest note when an access completes
  always @(posedge mclk) begin
    if (req.psel && req.penable && pready === 1'b1 && !req.pwrite) begin
      exp_s e;
      e = q.pop_front();
      check(prdata & e.m, e.d & e.m);
      check({31'h0, pslverr}, {31'h0, e.e});
    end
  end
  // Watchdog, far beyond the expected run length
  initial begin
    #100us;
    miscompares++;
    test_done;
  end
  initial begin
    wt(6);
    nrst <= 1'b1;
    wt(1);
    rd(C, 32'h0, 32'hF1F);
    rd(12'h008, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, S, $random(seed));
    rd(S, 32'h0, 32'h3);
    $display("test registers done");
    chan.on_phase <= 4'h1;
    apb(1'b1, C, 32'h108);
    rd(S, 32'h10, 32'h11);
    wt(30);
    rd(S, 32'h3, 32'h3);
    check({28'h0, half}, 32'h1);
    s0 = sign;
    chan.on_phase <= 4'h0;
    wt(5);
    check({31'h0, sign}, {31'h0, !s0});
    rd(S, 32'h0, 32'h3);
    chan <= '{4'h1, 4'h1, 4'h0, 4'h0};
    wt(3);
    rd(S, 32'h0, 32'h3);
    chan <= '{4'h1, 4'h0, 4'h0, 4'h1};
    wt(3);
    rd(S, 32'h20, 32'h21);
    chan.fault <= 4'h0;
    wt(3);
    rd(S, 32'h20, 32'h21);
    chan.on_phase <= 4'h0;
    wt(2);
    chan.on_phase <= 4'h1;
    wt(3);
    rd(S, 32'h1, 32'h21);
    $display("test valid setting done");
    chan.on_phase <= 4'h3;
    apb(1'b1, C, 32'h111);
    wt(30);
    rd(S, 32'h0, 32'h1);
    pulse;
    wt(3);
    rd(S, 32'h1, 32'h1);
    chan.full_duty <= 4'h2;
    wt(3);
    pulse;
    wt(1);
    rd(S, 32'h0, 32'h1);
    wt(15);
    rd(S, 32'h1, 32'h1);
    chan.full_duty <= 4'h0;
    apb(1'b1, C, 32'h001);
    wt(30);
    rd(S, 32'h0, 32'h1);
    $display("test trigger settings done");
    for (int s = 4; s < 6; s++) begin
      apb(1'b1, C, 32'(s));
      wt(5);
      n0 = samples;
      wt(100);
      check({31'h0, samples - n0 > 2}, 32'h1);
    end
    cf <= 1'b1;
    wt(3);
    rd(S, 32'h8, 32'h8);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, C, s ? 32'h009 : 32'h005);
      n0 = samples;
      wt(500);
      check({31'h0, samples - n0 > 2}, 32'h1);
    end
    cf <= 1'b0;
    $display("test square waves done");
    mode <= sense_sync_pkg::DEV_FAIL;
    wt(3);
    rd(C, 32'h0, 32'hF00);
    rd(S, 32'h0, 32'h3);
    apb(1'b1, C, 32'h109);
    rd(C, 32'h0, 32'hF00);
    check({28'h0, half}, 32'h0);
    mode <= sense_sync_pkg::DEV_SLEEP;
    wt(3);
    rd(S, 32'h0, 32'h3);
    $display("test device modes done");
    test_done;
  end
endmodule
`default_nettype wire
